/* chan_mon_pkg.sv */
// Purpose: Shared constants for the USB channel mode monitor.
// Assumes: 20 MHz system clock; all times are given in microseconds.
// Notes: Status and control layout is shared by the monitor and its bench.
package chan_mon_pkg;

  // Clock rate and chirp window limits
  localparam int CLK_MHZ = 20;
  localparam int CHIRP_MIN_US = 18;
  localparam int CHIRP_MAX_US = 128;
  // Least time rounds up, longest rounds down; both are exact at 20 MHz
  localparam int CHIRP_MIN_CYC = CHIRP_MIN_US * CLK_MHZ;
  localparam int CHIRP_MAX_CYC = CHIRP_MAX_US * CLK_MHZ;
  localparam int CNT_W = 12;

  // High speed bit rate carried while compensating, in Mbit/s
  localparam int HS_RATE_MBPS = 480;

  // Gain level width and the level used before the first capture
  localparam int GAIN_W = 2;
  localparam logic [1:0] GAIN_RST = 2'h3;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;

  // Control fields
  localparam int CTRL_SWDIS_BIT = 0;
  localparam logic CTRL_SWDIS_RST = 1'b0;

  // Status fields
  localparam int ST_ATTACH_BIT = 0;
  localparam int ST_HS_BIT = 1;
  localparam int ST_COMP_BIT = 2;
  localparam int ST_LOWSPD_BIT = 3;
  localparam int ST_GAIN_LSB = 4;
  localparam int ST_STATE_LSB = 8;

  // Channel modes, Gray coded along attach, reset, chirp J, chirp K, HS
  typedef enum logic [2:0] {
    MODE_UNCONN = 3'h0,
    MODE_ATTACH = 3'h1,
    MODE_RESET = 3'h3,
    MODE_CHIRP_J = 3'h2,
    MODE_CHIRP_K = 3'h6,
    MODE_HS = 3'h7,
    MODE_DISABLE = 3'h5
  } mode_t;

endpackage

/* chirp_timer.sv */
// Purpose: Measures how long the line has held one chirp level.
// Assumes: clear_i pulses on entry to each chirp state.
// Notes: The count saturates just past the longest legal chirp.
`timescale 1ns/10ps
module chirp_timer (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clear_i,
  input wire logic run_i,
  output logic in_win_o,
  output logic over_o
);

  logic [chan_mon_pkg::CNT_W-1:0] count_r;
  logic [chan_mon_pkg::CNT_W-1:0] count_nxt;
  logic sat_w;

  // Window ends cut to the counter width on purpose; both fit in it
  localparam logic [chan_mon_pkg::CNT_W-1:0] MIN_CNT =
    chan_mon_pkg::CHIRP_MIN_CYC[chan_mon_pkg::CNT_W-1:0];
  localparam logic [chan_mon_pkg::CNT_W-1:0] MAX_CNT =
    chan_mon_pkg::CHIRP_MAX_CYC[chan_mon_pkg::CNT_W-1:0];
  localparam logic [chan_mon_pkg::CNT_W-1:0] ONE_CNT =
    {{(chan_mon_pkg::CNT_W-1){1'b0}}, 1'b1};

  // Clear loads one, so the count equals the samples seen in the chirp
  // Saturation keeps a stuck chirp from wrapping back into the window
  assign sat_w = (count_r > MAX_CNT);
  assign count_nxt = clear_i ? ONE_CNT :
                     (run_i && !sat_w) ? count_r + 1'b1 : count_r;
  assign in_win_o = (count_r >= MIN_CNT) && !sat_w;
  assign over_o = sat_w;

  // Chirp length counter
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule

/* gain_latch.sv */
// Purpose: Holds the compensation gain level chosen by the strap input.
// Assumes: gain_select_input_i is already decoded to a level.
// Notes: Captures once after reset and once after each disable release.
`timescale 1ns/10ps
module gain_latch (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic disable_i,
  input wire logic [chan_mon_pkg::GAIN_W-1:0] gain_select_input_i,
  output logic [chan_mon_pkg::GAIN_W-1:0] gain_o,
  output logic capture_o
);

  logic armed_r;
  logic armed_nxt;
  logic [chan_mon_pkg::GAIN_W-1:0] gain_r;

  // Arm at reset and while disabled; fire on the first enabled cycle
  assign capture_o = armed_r && !disable_i;
  assign armed_nxt = disable_i ? 1'b1 : (capture_o ? 1'b0 : armed_r);
  assign gain_o = gain_r;

  // Strap sampling; later changes on the pin are ignored
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      armed_r <= 1'b1;
      gain_r <= chan_mon_pkg::GAIN_RST;
    end else begin
      armed_r <= armed_nxt;
      if (capture_o) begin
        gain_r <= gain_select_input_i;
      end
    end
  end

endmodule

/* test_usb_channel_mode_monitor.sv */
// Purpose: Self-checking bench for the USB channel mode monitor.
// Assumes: Flags follow the causing line sample by one edge.
// Notes: Chirps of 400 cycles sit inside the window; its ends are probed too.
`timescale 1ns/10ps
module test_usb_channel_mode_monitor;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic active_low_disable = 1'b1;
  logic [1:0] strap = 2'h1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, attach_flag_o, high_speed_flag_o, comp_en_o;
  logic [1:0] comp_gain_o;
  logic dp, dm, disc, susp;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;

  // 50 ns period
  always #25 sys_clk_i = ~sys_clk_i;

  usb_line_partner far (.sys_clk_i(sys_clk_i), .line_dp_o(dp),
    .line_dm_o(dm), .disc_o(disc), .susp_o(susp));

  usb_channel_mode_monitor dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .active_low_disable_i(active_low_disable), .gain_select_input_i(strap),
    .line_dp_i(dp), .line_dm_i(dm), .disc_det_i(disc),
    .suspend_det_i(susp), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .attach_flag_o(attach_flag_o), .high_speed_flag_o(high_speed_flag_o),
    .comp_en_o(comp_en_o), .comp_gain_o(comp_gain_o));

  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run needs about 11000 cycles; a hang is cut here
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Outputs are read mid-cycle; gain only matters while compensating
  task automatic chk_out(input logic a, h, c, input logic [1:0] g);
    @(negedge sys_clk_i);
    cmp({29'h0, attach_flag_o, high_speed_flag_o, comp_en_o}, {29'h0, a, h, c});
    if (c) cmp({30'h0, comp_gain_o}, {30'h0, g});
    @(posedge sys_clk_i);
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  // Expected status word: flags, gain and mode code
  function automatic logic [31:0] st(input logic [3:0] f,
                                     input logic [1:0] g,
                                     input logic [2:0] m);
    return {21'h0, m, 2'h0, g, f};
  endfunction

  // Disconnect: device leaves, lines fall, detector pulses
  task automatic unplug;
    far.drive(1'b0, 1'b0, 0);
    far.det(1'b1, 1'b0);
  endtask

  initial begin
    repeat (4) @(posedge sys_clk_i);
    chk_out(1'b0, 1'b0, 1'b0, 2'h0);
    cmp({30'h0, comp_gain_o}, {30'h0, chan_mon_pkg::GAIN_RST});
    srst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    // Later strap changes must be ignored until disable toggles
    strap <= 2'h2;
    far.drive(1'b1, 1'b0, 2);
    chk_out(1'b1, 1'b0, 1'b0, 2'h0);
    apb(1'b0, chan_mon_pkg::STATUS_OFS, 32'h0);
    cmp(rd, st(4'h1, 2'h1, chan_mon_pkg::MODE_ATTACH));
    cmp({30'h0, pready_o, er}, 32'h2);
    unplug();
    chk_out(1'b0, 1'b0, 1'b0, 2'h0);
    far.drive(1'b0, 1'b1, 2);
    chk_out(1'b1, 1'b0, 1'b0, 2'h0);
    apb(1'b0, chan_mon_pkg::STATUS_OFS, 32'h0);
    cmp(rd, st(4'h9, 2'h1, chan_mon_pkg::MODE_ATTACH));
    unplug();
    // A J chirp shorter than the window must not reach high speed
    far.drive(1'b1, 1'b0, 2);
    far.handshake(200, 400);
    chk_out(1'b1, 1'b0, 1'b0, 2'h0);
    unplug();
    far.drive(1'b1, 1'b0, 2);
    far.handshake(400, 400);
    chk_out(1'b1, 1'b1, 1'b1, 2'h1);
    apb(1'b0, chan_mon_pkg::STATUS_OFS, 32'h0);
    cmp(rd, st(4'h7, 2'h1, chan_mon_pkg::MODE_HS));
    far.det(1'b0, 1'b1);
    chk_out(1'b1, 1'b0, 1'b0, 2'h0);
    far.handshake(400, 400);
    chk_out(1'b1, 1'b1, 1'b1, 2'h1);
    unplug();
    chk_out(1'b0, 1'b0, 1'b0, 2'h0);
    // Window ends: 360 and 2560 samples pass, 359 and 2561 fall back
    far.drive(1'b1, 1'b0, 2);
    far.handshake(360, 2560);
    chk_out(1'b1, 1'b1, 1'b1, 2'h1);
    far.det(1'b0, 1'b1);
    far.handshake(359, 400);
    chk_out(1'b1, 1'b0, 1'b0, 2'h0);
    far.handshake(400, 2561);
    chk_out(1'b1, 1'b0, 1'b0, 2'h0);
    unplug();
    // Pin disable in high speed while traffic keeps moving
    far.drive(1'b1, 1'b0, 2);
    far.handshake(400, 400);
    active_low_disable <= 1'b0;
    far.drive(1'b1, 1'b0, 3);
    chk_out(1'b0, 1'b0, 1'b0, 2'h0);
    far.drive(1'b0, 1'b0, 0);
    active_low_disable <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    chk_out(1'b0, 1'b0, 1'b0, 2'h0);
    far.drive(1'b1, 1'b0, 2);
    far.handshake(400, 400);
    chk_out(1'b1, 1'b1, 1'b1, 2'h2);
    // Software disable, read-only status and an unmapped address
    apb(1'b1, chan_mon_pkg::CTRL_OFS, 32'h1);
    chk_out(1'b0, 1'b0, 1'b0, 2'h0);
    apb(1'b0, chan_mon_pkg::STATUS_OFS, 32'h0);
    cmp(rd & 32'h0000070f, 32'h00000500);
    apb(1'b1, chan_mon_pkg::STATUS_OFS, 32'hffffffff);
    apb(1'b0, chan_mon_pkg::STATUS_OFS, 32'h0);
    cmp(rd & 32'h0000070f, 32'h00000500);
    apb(1'b1, 12'h008, 32'h0);
    cmp({31'h0, er}, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    cmp({31'h0, er}, 32'h1);
    cmp(rd, 32'h0);
    apb(1'b0, chan_mon_pkg::CTRL_OFS, 32'h0);
    cmp(rd, 32'h1);
    apb(1'b1, chan_mon_pkg::CTRL_OFS, 32'h0);
    repeat (3) @(posedge sys_clk_i);
    chk_out(1'b0, 1'b0, 1'b0, 2'h0);
    far.drive(1'b1, 1'b0, 2);
    chk_out(1'b1, 1'b0, 1'b0, 2'h0);
    report_and_stop;
  end
endmodule

/* usb_channel_mode_monitor.sv */
// Purpose: Tracks the speed mode of a passive USB channel and drives flags.
// Assumes: Line and detector inputs are synchronous to sys_clk_i.
// Notes: Data never passes through this logic; it only steers compensation.
//
// Behaviour
// - A low speed attach leaves compensation off and raises the attach flag.
// - A full speed attach leaves compensation off and raises the attach flag.
// - A high speed attach turns compensation on at the captured gain level.
// - In high speed mode both the high speed and the attach flags are high.
// - While the disable input is low the block is disabled, no compensation.
// - Disabled, traffic still passes and neither flag reports status.
// - High speed mode carries traffic at up to 480 Mbit/s.
// - One chirp J then one chirp K, each 18 to 128 us, make high speed.
// - Disconnect or suspend drops the high speed flag.
// - A pull-up seen while unconnected raises attach; disconnect clears it.
// - Gain is captured only after reset or disable release, then held.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module usb_channel_mode_monitor (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic active_low_disable_i,
  input wire logic [chan_mon_pkg::GAIN_W-1:0] gain_select_input_i,
  input wire logic line_dp_i,
  input wire logic line_dm_i,
  input wire logic disc_det_i,
  input wire logic suspend_det_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic attach_flag_o,
  output logic high_speed_flag_o,
  output logic comp_en_o,
  output logic [chan_mon_pkg::GAIN_W-1:0] comp_gain_o
);

  chan_mon_pkg::mode_t state_r;
  chan_mon_pkg::mode_t state_nxt;
  logic lowspeed_r;
  logic lowspeed_nxt;
  logic attach_r;
  logic attach_nxt;
  logic hs_r;
  logic hs_nxt;
  logic comp_r;
  logic comp_nxt;
  logic swdis_r;
  logic [31:0] prdata_r;
  logic [31:0] status_w;
  logic dis_w;
  logic se0_w;
  logic lj_w;
  logic lk_w;
  logic pullup_w;
  logic tmr_clear_w;
  logic tmr_run_w;
  logic in_win_w;
  logic over_w;
  logic [chan_mon_pkg::GAIN_W-1:0] gain_w;
  logic capture_w;
  logic hit_ctrl_w;
  logic hit_status_w;
  logic setup_w;
  logic access_w;

  // Line decode from the single-ended receivers
  assign se0_w = !line_dp_i && !line_dm_i;
  assign lj_w = line_dp_i && !line_dm_i;
  assign lk_w = !line_dp_i && line_dm_i;
  assign pullup_w = line_dp_i || line_dm_i;

  // Pin and software disable are merged; either one parks the block
  assign dis_w = !active_low_disable_i || swdis_r;

  // Chirp timer restarts on every state change and runs only in chirps
  assign tmr_clear_w = (state_nxt != state_r);
  assign tmr_run_w = (state_r == chan_mon_pkg::MODE_CHIRP_J) ||
                     (state_r == chan_mon_pkg::MODE_CHIRP_K);

  chirp_timer u_chirp_timer (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .clear_i(tmr_clear_w),
    .run_i(tmr_run_w),
    .in_win_o(in_win_w),
    .over_o(over_w)
  );

  gain_latch u_gain_latch (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .disable_i(dis_w),
    .gain_select_input_i(gain_select_input_i),
    .gain_o(gain_w),
    .capture_o(capture_w)
  );

  // Mode tracking; disable overrides everything, disconnect comes next
  always_comb begin
    state_nxt = state_r;
    lowspeed_nxt = lowspeed_r;
    case (state_r)
      chan_mon_pkg::MODE_UNCONN: begin
        if (pullup_w) begin
          state_nxt = chan_mon_pkg::MODE_ATTACH;
          lowspeed_nxt = lk_w;
        end
      end
      chan_mon_pkg::MODE_ATTACH: begin
        // A low speed device never chirps, so bus reset is ignored for it
        if (disc_det_i) begin
          state_nxt = chan_mon_pkg::MODE_UNCONN;
        end else if (se0_w && !lowspeed_r) begin
          state_nxt = chan_mon_pkg::MODE_RESET;
        end
      end
      chan_mon_pkg::MODE_RESET: begin
        if (disc_det_i) begin
          state_nxt = chan_mon_pkg::MODE_UNCONN;
        end else if (lj_w) begin
          state_nxt = chan_mon_pkg::MODE_CHIRP_J;
        end else if (lk_w) begin
          state_nxt = chan_mon_pkg::MODE_ATTACH;
        end
      end
      chan_mon_pkg::MODE_CHIRP_J: begin
        // Plain full speed idle after reset times out here as a long J
        if (disc_det_i) begin
          state_nxt = chan_mon_pkg::MODE_UNCONN;
        end else if (over_w) begin
          state_nxt = chan_mon_pkg::MODE_ATTACH;
        end else if (lk_w) begin
          state_nxt = in_win_w ? chan_mon_pkg::MODE_CHIRP_K
                               : chan_mon_pkg::MODE_ATTACH;
        end else if (se0_w) begin
          state_nxt = chan_mon_pkg::MODE_RESET;
        end
      end
      chan_mon_pkg::MODE_CHIRP_K: begin
        if (disc_det_i) begin
          state_nxt = chan_mon_pkg::MODE_UNCONN;
        end else if (over_w) begin
          state_nxt = chan_mon_pkg::MODE_ATTACH;
        end else if (!lk_w) begin
          state_nxt = in_win_w ? chan_mon_pkg::MODE_HS
                               : chan_mon_pkg::MODE_ATTACH;
        end
      end
      chan_mon_pkg::MODE_HS: begin
        if (disc_det_i) begin
          state_nxt = chan_mon_pkg::MODE_UNCONN;
        end else if (suspend_det_i) begin
          state_nxt = chan_mon_pkg::MODE_ATTACH;
        end
      end
      chan_mon_pkg::MODE_DISABLE: begin
        state_nxt = chan_mon_pkg::MODE_UNCONN;
      end
      default: begin
        state_nxt = chan_mon_pkg::MODE_UNCONN;
      end
    endcase
    if (dis_w) begin
      state_nxt = chan_mon_pkg::MODE_DISABLE;
    end
  end

  // Flag and compensation outputs follow the next mode, so they are flops
  assign attach_nxt = (state_nxt != chan_mon_pkg::MODE_UNCONN) &&
                      (state_nxt != chan_mon_pkg::MODE_DISABLE);
  assign hs_nxt = (state_nxt == chan_mon_pkg::MODE_HS);
  // Compensation only in HS; the equaliser path is sized rates
  assign comp_nxt = (state_nxt == chan_mon_pkg::MODE_HS);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_r <= chan_mon_pkg::MODE_UNCONN;
      lowspeed_r <= 1'b0;
      attach_r <= 1'b0;
      hs_r <= 1'b0;
      comp_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      lowspeed_r <= lowspeed_nxt;
      attach_r <= attach_nxt;
      hs_r <= hs_nxt;
      comp_r <= comp_nxt;
    end
  end

  assign attach_flag_o = attach_r;
  assign high_speed_flag_o = hs_r;
  assign comp_en_o = comp_r;
  assign comp_gain_o = gain_w;

  // APB decode; zero wait states, unmapped words answer with an error
  assign setup_w = psel_i && !penable_i;
  assign access_w = psel_i && penable_i;
  assign hit_ctrl_w = (paddr_i == chan_mon_pkg::CTRL_OFS);
  assign hit_status_w = (paddr_i == chan_mon_pkg::STATUS_OFS);
  assign pready_o = 1'b1;
  assign pslverr_o = access_w && !hit_ctrl_w && !hit_status_w;
  assign prdata_o = prdata_r;

  // Status word; unused bits read as zero
  always_comb begin
    status_w = '0;
    status_w[chan_mon_pkg::ST_ATTACH_BIT] = attach_r;
    status_w[chan_mon_pkg::ST_HS_BIT] = hs_r;
    status_w[chan_mon_pkg::ST_COMP_BIT] = comp_r;
    status_w[chan_mon_pkg::ST_LOWSPD_BIT] = lowspeed_r;
    status_w[chan_mon_pkg::ST_GAIN_LSB +: chan_mon_pkg::GAIN_W] = gain_w;
    status_w[chan_mon_pkg::ST_STATE_LSB +: 3] = state_r;
  end

  // Read data is loaded in the setup cycle so it is a flop at access
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prdata_r <= '0;
      swdis_r <= chan_mon_pkg::CTRL_SWDIS_RST;
    end else begin
      if (setup_w && !pwrite_i) begin
        prdata_r <= hit_ctrl_w ? {31'h0, swdis_r} :
                    hit_status_w ? status_w : 32'h0;
      end
      if (access_w && pwrite_i && hit_ctrl_w) begin
        swdis_r <= pwdata_i[chan_mon_pkg::CTRL_SWDIS_BIT];
      end
    end
  end

  // Checks of mode behaviour against the line and detector inputs
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  AST_LS_ATTACH: assert property (
    (state_r == chan_mon_pkg::MODE_UNCONN) && !dis_w && lk_w
    |=> attach_flag_o && !comp_en_o && lowspeed_r)
    else $error("low speed attach did not raise attach alone");

  AST_FS_ATTACH: assert property (
    (state_r == chan_mon_pkg::MODE_UNCONN) && !dis_w && lj_w
    |=> attach_flag_o && !comp_en_o && !lowspeed_r)
    else $error("full speed attach did not raise attach alone");

  AST_HS_COMP: assert property (
    high_speed_flag_o |-> comp_en_o)
    else $error("high speed mode without compensation");

  AST_COMP_ONLY_HS: assert property (
    comp_en_o |-> high_speed_flag_o)
    else $error("compensation active outside high speed");

  AST_GAIN_CAPTURE: assert property (
    capture_w |=> (comp_gain_o == $past(gain_select_input_i)))
    else $error("gain level not taken from the strap at capture");

  AST_HS_ATTACH: assert property (
    high_speed_flag_o |-> attach_flag_o)
    else $error("high speed flag without attach flag");

  AST_DIS_NO_COMP: assert property (
    !active_low_disable_i |=> !comp_en_o)
    else $error("compensation active while disabled");

  AST_DIS_FLAGS: assert property (
    dis_w ##1 dis_w |-> !attach_flag_o && !high_speed_flag_o)
    else $error("flag reported while disabled");

  AST_CHIRP_PAIR: assert property (
    (state_r == chan_mon_pkg::MODE_CHIRP_K) && !dis_w && !disc_det_i &&
    !lk_w && in_win_w |=> high_speed_flag_o)
    else $error("valid chirp pair did not enter high speed");

  AST_HS_DROP: assert property (
    high_speed_flag_o && (disc_det_i || suspend_det_i)
    |=> !high_speed_flag_o)
    else $error("high speed flag kept after disconnect or suspend");

  AST_DISC_CLEAR: assert property (
    attach_flag_o && disc_det_i |=> !attach_flag_o)
    else $error("attach flag kept after disconnect");

  AST_GAIN_HOLD: assert property (
    !capture_w |=> $stable(comp_gain_o))
    else $error("gain changed outside a capture");

  AST_RELEASE_LOW: assert property (
    $fell(dis_w) |=> !attach_flag_o && !high_speed_flag_o)
    else $error("flags rose at release");

  AST_RELEASE_HOLD: assert property (
    $fell(dis_w) ##1 !pullup_w |=> !attach_flag_o && !high_speed_flag_o)
    else $error("flags rose after release without connection");

  COV_LS: cover property (
    (state_r == chan_mon_pkg::MODE_ATTACH) && lowspeed_r);
  COV_HS: cover property ($rose(high_speed_flag_o));
  COV_SUSPEND: cover property (high_speed_flag_o && suspend_det_i);
  COV_DISABLE: cover property ($fell(dis_w));

endmodule

/* usb_line_partner.sv */
// Purpose: Far-side USB transceivers that drive the monitored channel.
// Assumes: Every call starts right after a rising edge of sys_clk_i.
// Notes: Detector outputs stand in for analog disconnect and suspend sense.
`timescale 1ns/10ps
module usb_line_partner (
  input wire logic sys_clk_i,
  output logic line_dp_o,
  output logic line_dm_o,
  output logic disc_o,
  output logic susp_o
);
  // Unattached lines rest low through the host pull-downs
  initial begin
    line_dp_o = 1'b0;
    line_dm_o = 1'b0;
    disc_o = 1'b0;
    susp_o = 1'b0;
  end

  // Hold one line state for n edges; dp high is J, dm high is K
  task automatic drive(input logic dp, input logic dm, input int n);
    line_dp_o <= dp;
    line_dm_o <= dm;
    repeat (n) @(posedge sys_clk_i);
  endtask

  // One-cycle detector pulse; never called twice at the same edge
  task automatic det(input logic d, input logic s);
    disc_o <= d;
    susp_o <= s;
    @(posedge sys_clk_i);
    disc_o <= 1'b0;
    susp_o <= 1'b0;
  endtask

  // Bus reset, then one chirp J and one chirp K, then SE0 ends the K
  task automatic handshake(input int j, input int k);
    drive(1'b0, 1'b0, 4);
    drive(1'b1, 1'b0, j);
    drive(1'b0, 1'b1, k);
    drive(1'b0, 1'b0, 1);
  endtask
endmodule
